// ---- core/sps_step_phase_sequencer.sv ----
// Purpose: Digital indexer of a two-phase bipolar stepper driver with a Wishbone control slave.
// Assumes: Step, direction, enable, angle reset and resolution pins are asynchronous to ref_clk_i.
// Notes:   Bridge and monitor pins are reported as value plus output enable; released means high impedance.
// Function
// - Each step rising edge advances one resolution step.
// - Step falling edge leaves angle unchanged.
// - Enable high drives bridges, low floats them.
// - Clockwise: phase A leads phase B by 90.
// - Counterclockwise: phase B leads phase A by 90.
// - Selector all low: standby, oscillator stopped, bridges off.
// - Decode selector bits into seven step resolutions.
// - Angle reset high holds initial angle.
// - Monitor pulled low while angle reset active.
// - Initial angle is 45 degrees, every resolution.
`include "sps_regs.svh"
module sps_step_phase_sequencer
  import sps_pkg::*;
#(
  parameter int CHOP_CYC = `SPS_CHOP_CYC
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Host pins.
  input  wire logic        step_pulse_i,
  input  wire logic        rotation_direction_in_i,
  input  wire logic        output_enable_i,
  input  wire logic        angle_reset_i,
  input  wire logic        step_res_sel_bit0_i,
  input  wire logic        step_res_sel_bit1_i,
  input  wire logic        step_res_sel_bit2_i,
  // Bridge outputs.
  output logic             phase_a_pos_out_o,
  output logic             phase_a_pos_out_oe_o,
  output logic             phase_a_neg_out_o,
  output logic             phase_a_neg_out_oe_o,
  output logic             phase_b_pos_out_o,
  output logic             phase_b_pos_out_oe_o,
  output logic             phase_b_neg_out_o,
  output logic             phase_b_neg_out_oe_o,
  // Open-drain angle monitor and chopping tick.
  output logic             angle_home_monitor_o,
  output logic             angle_home_monitor_oe_o,
  output logic             chop_oscillator_tick_o,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  localparam int AW = `SPS_ANGLE_W;  // Angle counter width.

  sps_pin_if #(.W(7)) pin_bus ();  // Pin group into the synchroniser.

  // Order: step, direction, enable, angle reset, selector bit0..bit2.
  assign pin_bus.raw = {step_pulse_i, rotation_direction_in_i, output_enable_i, angle_reset_i,
                        step_res_sel_bit0_i, step_res_sel_bit1_i, step_res_sel_bit2_i};

  sps_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .pins      (pin_bus)
  );

  logic          step_s;      // Synchronised step level.
  logic          dir_s;       // Synchronised direction, high is clockwise.
  logic          en_s;        // Synchronised output enable.
  logic          arst_pin_s;  // Synchronised angle reset pin.
  logic [2:0]    sel_s;       // Selector as {bit0, bit1, bit2}.
  assign {step_s, dir_s, en_s, arst_pin_s, sel_s} = pin_bus.sync;

  // State registers and their next values.
  logic          step_d,  next_step_d;   // Previous step level for edge detection.
  logic [AW-1:0] angle,   next_angle;    // Electrical angle position.
  logic [1:0]    ctrl,    next_ctrl;     // Software control bits.
  logic [7:0]    chop_cnt, next_chop_cnt; // Chopping divider.
  logic          chop_tick, next_chop_tick;
  logic [3:0]    br_val,  next_br_val;   // Bridge levels: a+, a-, b+, b-.
  logic          br_oe,   next_br_oe;    // Bridges driven.
  logic          mon_oe,  next_mon_oe;   // Monitor pulling low.
  logic          ack,     next_ack;
  logic [31:0]   rdata,   next_rdata;

  sps_mode_t     mode;        // Decoded resolution.
  logic [AW-1:0] step_size;   // Angle increment for this resolution.
  logic          arst;        // Angle reset from pin or software.
  logic          step_rise;   // One-cycle rising edge of step.

  // Decode the selector into a resolution and its step size.
  always_comb begin
    mode      = SPS_STANDBY;
    step_size = '0;
    case (sel_s)
      3'h1: begin mode = SPS_FULL;      step_size = `SPS_STEP_FULL;      end
      3'h2: begin mode = SPS_HALF_A;    step_size = `SPS_STEP_HALF;      end
      3'h3: begin mode = SPS_QUARTER;   step_size = `SPS_STEP_QUARTER;   end
      3'h4: begin mode = SPS_HALF_B;    step_size = `SPS_STEP_HALF;      end
      3'h5: begin mode = SPS_EIGHTH;    step_size = `SPS_STEP_EIGHTH;    end
      3'h6: begin mode = SPS_SIXTEENTH; step_size = `SPS_STEP_SIXTEENTH; end
      3'h7: begin mode = SPS_THIRTYTWO; step_size = `SPS_STEP_THIRTYTWO; end
      default: begin mode = SPS_STANDBY; step_size = '0; end
    endcase
  end

  assign arst      = arst_pin_s | ctrl[`SPS_CTRL_ARST_BIT];
  assign step_rise = step_s & ~step_d;

  // Angle next value: reset wins, otherwise move on a rising step edge only.
  always_comb begin
    next_step_d = step_s;
    next_angle  = angle;
    if (arst) begin
      next_angle = `SPS_ANGLE_INIT;
    end else if (step_rise && mode != SPS_STANDBY) begin
      // Up counts clockwise, down counts counterclockwise, wrapping per cycle.
      if (dir_s) begin
        next_angle = angle + step_size;
      end else begin
        next_angle = angle - step_size;
      end
    end
  end

  // Chopping divider: stopped and cleared in standby.
  always_comb begin
    next_chop_cnt  = chop_cnt;
    next_chop_tick = 1'b0;
    if (mode == SPS_STANDBY) begin
      next_chop_cnt = '0;
    end else if (chop_cnt == 8'(CHOP_CYC - 1)) begin
      next_chop_cnt  = '0;
      next_chop_tick = 1'b1;
    end else begin
      next_chop_cnt = chop_cnt + 8'h01;
    end
  end

  // Bridge polarity from the angle: phase A follows the cosine, phase B the sine,
  // so counting up puts A 90 degrees ahead and counting down puts B ahead.
  always_comb begin
    logic a_zero;
    logic a_pos;
    logic b_zero;
    logic b_pos;
    a_zero = 1'b0;
    a_pos  = 1'b0;
    b_zero = 1'b0;
    b_pos  = 1'b0;
    a_zero = (angle == `SPS_ANGLE_90) || (angle == `SPS_ANGLE_270);
    a_pos  = (angle < `SPS_ANGLE_90) || (angle > `SPS_ANGLE_270);
    b_zero = (angle == '0) || (angle == `SPS_ANGLE_180);
    b_pos  = (angle < `SPS_ANGLE_180);
    // Positive current: plus high, minus low; negative: the reverse; zero: both low.
    next_br_val = {a_pos & ~a_zero, ~a_pos & ~a_zero, b_pos & ~b_zero, ~b_pos & ~b_zero};
    // Driven only with enable high, outside standby, and with software gate set.
    next_br_oe  = en_s && (mode != SPS_STANDBY) && ctrl[`SPS_CTRL_GATE_BIT];
    // Monitor pulls low during angle reset or at the initial angle.
    next_mon_oe = arst || (angle == `SPS_ANGLE_INIT);
  end

  // Wishbone slave: one-cycle registered answer, unmapped reads give zero.
  always_comb begin
    next_ctrl  = ctrl;
    next_ack   = wb_cyc_i && wb_stb_i && !ack;
    next_rdata = '0;
    if (wb_cyc_i && wb_stb_i && !ack) begin
      if (wb_adr_i == `SPS_ADR_CTRL) begin
        if (wb_we_i && wb_sel_i[0]) begin
          next_ctrl = wb_dat_i[1:0];
        end
        next_rdata = {30'h0, ctrl};
      end else if (wb_adr_i == `SPS_ADR_STATUS) begin
        next_rdata[`SPS_ST_ANGLE_LSB +: AW] = angle;
        next_rdata[`SPS_ST_MODE_LSB +: 8]   = mode;
        next_rdata[`SPS_ST_HOME_BIT]        = mon_oe;
        next_rdata[`SPS_ST_BRIDGE_BIT]      = br_oe;
        next_rdata[`SPS_ST_DIR_BIT]         = dir_s;
        next_rdata[`SPS_ST_ARST_BIT]        = arst;
      end else begin
        next_rdata = '0;
      end
    end
  end

  // Register all state.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_d    <= 1'b0;
      angle     <= `SPS_ANGLE_INIT;
      ctrl      <= `SPS_CTRL_RESET;
      chop_cnt  <= '0;
      chop_tick <= 1'b0;
      br_val    <= '0;
      br_oe     <= 1'b0;
      mon_oe    <= 1'b0;
      ack       <= 1'b0;
      rdata     <= '0;
    end else begin
      step_d    <= next_step_d;
      angle     <= next_angle;
      ctrl      <= next_ctrl;
      chop_cnt  <= next_chop_cnt;
      chop_tick <= next_chop_tick;
      br_val    <= next_br_val;
      br_oe     <= next_br_oe;
      mon_oe    <= next_mon_oe;
      ack       <= next_ack;
      rdata     <= next_rdata;
    end
  end

  // Outputs straight from flip-flops, except the monitor value, which is tied low.
  assign {phase_a_pos_out_o, phase_a_neg_out_o, phase_b_pos_out_o, phase_b_neg_out_o} = br_val;
  assign phase_a_pos_out_oe_o    = br_oe;
  assign phase_a_neg_out_oe_o    = br_oe;
  assign phase_b_pos_out_oe_o    = br_oe;
  assign phase_b_neg_out_oe_o    = br_oe;
  assign angle_home_monitor_o    = 1'b0;
  assign angle_home_monitor_oe_o = mon_oe;
  assign chop_oscillator_tick_o  = chop_tick;
  assign wb_ack_o                = ack;
  assign wb_dat_o                = rdata;

endmodule // sps_step_phase_sequencer

// ---- core/sps_sync.sv ----
// Purpose: Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes: Each pin is an independent level; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
module sps_sync (
  // Clock and reset.
  input wire logic   ref_clk_i,
  input wire logic   reset_n_i,
  // Pin group.
  sps_pin_if.syncer  pins
);

  logic [$bits(pins.raw)-1:0] meta;       // First stage, metastable-prone.
  logic [$bits(pins.raw)-1:0] stable;     // Second stage.
  logic [$bits(pins.raw)-1:0] next_meta;  // Next first stage.
  logic [$bits(pins.raw)-1:0] next_stable; // Next second stage.

  // Next values: shift the pins one stage along.
  always_comb begin
    next_meta   = pins.raw;
    next_stable = meta;
  end

  // Register both stages.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
    end
  end

  assign pins.sync = stable;

endmodule // sps_sync

// ---- pkg/sps_pin_if.sv ----
// Purpose: Carries raw pin levels into the synchroniser and the clean levels back out.
// Assumes: Both ends share ref_clk_i.
// Notes:   Width is the number of pins carried.
interface sps_pin_if #(parameter int W = 1);
  logic [W-1:0] raw;   // Asynchronous pin levels.
  logic [W-1:0] sync;  // Levels after two flip-flops.
  modport user   (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface

// ---- pkg/sps_pkg.sv ----
// Purpose: Types shared by the step phase sequencer files.
// Assumes: Constants live in sps_regs.svh.
// Notes:   The resolution enum is one-hot.
package sps_pkg;

  // Decoded step resolution, one-hot.
  typedef enum logic [7:0] {
    SPS_STANDBY   = 8'h01,
    SPS_FULL      = 8'h02,
    SPS_HALF_A    = 8'h04,
    SPS_QUARTER   = 8'h08,
    SPS_HALF_B    = 8'h10,
    SPS_EIGHTH    = 8'h20,
    SPS_SIXTEENTH = 8'h40,
    SPS_THIRTYTWO = 8'h80
  } sps_mode_t;

endpackage

// ---- pkg/sps_regs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the step phase sequencer.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Angle unit is 1/128 of an electrical cycle (2.8125 degrees).
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// Register byte offsets on the Wishbone slave.
`define SPS_ADR_CTRL        8'h00
`define SPS_ADR_STATUS      8'h04

// Control register fields and reset value.
`define SPS_CTRL_ARST_BIT   0
`define SPS_CTRL_GATE_BIT   1
`define SPS_CTRL_RESET      2'h2

// Status register field positions.
`define SPS_ST_ANGLE_LSB    0
`define SPS_ST_MODE_LSB     8
`define SPS_ST_HOME_BIT     16
`define SPS_ST_BRIDGE_BIT   17
`define SPS_ST_DIR_BIT      18
`define SPS_ST_ARST_BIT     19

// Angle counter: 128 positions per electrical cycle, initial angle 45 degrees.
`define SPS_ANGLE_W         7
`define SPS_ANGLE_INIT      7'h10
`define SPS_ANGLE_90        7'h20
`define SPS_ANGLE_180       7'h40
`define SPS_ANGLE_270       7'h60

// Angle increment per step for each resolution.
`define SPS_STEP_FULL       7'h20
`define SPS_STEP_HALF       7'h10
`define SPS_STEP_QUARTER    7'h08
`define SPS_STEP_EIGHTH     7'h04
`define SPS_STEP_SIXTEENTH  7'h02
`define SPS_STEP_THIRTYTWO  7'h01

// Chopping oscillator rate and its divider count (longest period, rounded down).
`define SPS_CLK_KHZ         200000
`define SPS_CHOP_KHZ        1120
`define SPS_CHOP_CYC        (`SPS_CLK_KHZ / `SPS_CHOP_KHZ)

`endif

// ---- tb/sps_host_model.sv ----
// Purpose: Host controller model that drives the indexer pins.
// Assumes: Shares ref_clk_i with the device and changes pins just after rising edges.
// Notes:   Step high and low each last 3 cycles, so pulses are 6 cycles apart.
module sps_host_model (
  // Clock.
  input  wire logic  ref_clk_i,
  // Pins toward the device.
  output logic       step_o,
  output logic       dir_o,
  output logic       en_o,
  output logic       arst_o,
  output logic [2:0] sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enable starts low so the bridges stay off while the supply ramps.
  initial begin
    {step_o, dir_o, en_o, arst_o, sel_o} = '0;
  end
  // Issues n step pulses in one direction, then lets the outputs settle.
  task automatic steps(input int n, input logic d);
    dir_o <= d;
    repeat (n) begin
      repeat (3) @(posedge ref_clk_i);
      step_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      step_o <= 1'b0;
    end
    repeat (8) @(posedge ref_clk_i);
  endtask
  // Selects a resolution and re-homes the angle, which a mode change needs.
  task automatic mode(input logic [2:0] s);
    sel_o  <= s;
    arst_o <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    arst_o <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask
endmodule // sps_host_model

// ---- tb/sps_step_phase_sequencer_asserts.sv ----
// Purpose: Port-level checker of the step phase sequencer.
// Assumes: Bound to the top module; pins reach the logic through two flip-flops.
// Notes:   Latency margins cover the synchroniser and output registers.
module sps_step_phase_sequencer_asserts #(
  parameter int CHOP_CYC = 178
) (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        output_enable_i,
  input wire logic        angle_reset_i,
  input wire logic        step_res_sel_bit0_i,
  input wire logic        step_res_sel_bit1_i,
  input wire logic        step_res_sel_bit2_i,
  input wire logic        phase_a_pos_out_o,
  input wire logic        phase_a_neg_out_o,
  input wire logic        phase_b_pos_out_o,
  input wire logic        phase_b_neg_out_o,
  input wire logic        phase_a_pos_out_oe_o,
  input wire logic        phase_b_neg_out_oe_o,
  input wire logic        phase_a_neg_out_oe_o,
  input wire logic        phase_b_pos_out_oe_o,
  input wire logic        angle_home_monitor_o,
  input wire logic        angle_home_monitor_oe_o,
  input wire logic        chop_oscillator_tick_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stby;      // Selector pins all low.
  int   gap;       // Cycles since the last chopping tick.
  int   next_gap;  // Next value of gap.
  assign stby = !(step_res_sel_bit0_i | step_res_sel_bit1_i | step_res_sel_bit2_i);
  // The gap restarts on a tick and while standby stops the oscillator.
  always_comb next_gap = (chop_oscillator_tick_o || stby) ? 0 : gap + 1;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) gap <= !reset_n_i ? 0 : next_gap;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // All four bridge enables must move together.
  oe_match_a: assert property (phase_a_pos_out_oe_o == phase_b_neg_out_oe_o &&
    phase_a_neg_out_oe_o == phase_a_pos_out_oe_o && phase_b_pos_out_oe_o == phase_a_pos_out_oe_o) else $error("oe differ");
  enable_off_a: assert property (!output_enable_i [*5] |-> !phase_a_pos_out_oe_o) else $error("oe on");
  standby_off_a: assert property (stby [*5] |-> !phase_b_neg_out_oe_o && !chop_oscillator_tick_o)
    else $error("standby active");
  legs_excl_a: assert property (!(phase_a_pos_out_o && phase_a_neg_out_o) &&
    !(phase_b_pos_out_o && phase_b_neg_out_o)) else $error("both legs high");
  // The host holds angle reset for five cycles, so four samples must already pull the monitor low.
  home_hold_a: assert property (angle_reset_i [*4] |-> angle_home_monitor_oe_o) else $error("monitor off");
  // The open-drain value is always low; only its enable says whether it pulls.
  mon_value_a: assert property (!angle_home_monitor_o) else $error("monitor value high");
  tick_gap_a: assert property (gap <= CHOP_CYC + 4) else $error("tick missing");
  tick_single_a: assert property (chop_oscillator_tick_o |=> !chop_oscillator_tick_o) else $error("tick long");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  cover property (angle_home_monitor_oe_o ##1 !angle_home_monitor_oe_o);
  cover property (stby [*5]);
  cover property (chop_oscillator_tick_o);
endmodule // sps_step_phase_sequencer_asserts

// ---- tb/tb_step_phase_sequencer.sv ----
// Purpose: Self-checking bench of the step phase sequencer.
// Assumes: Angle and mode are read back from the status register.
// Notes:   Chopping divider shortened to 8 cycles.
`include "sps_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
bind sps_step_phase_sequencer sps_step_phase_sequencer_asserts #(.CHOP_CYC(CHOP_CYC)) chk_inst (.ref_clk_i,
  .reset_n_i, .output_enable_i, .angle_reset_i, .step_res_sel_bit0_i, .step_res_sel_bit1_i, .step_res_sel_bit2_i,
  .phase_a_pos_out_o, .phase_a_neg_out_o, .phase_b_pos_out_o, .phase_b_neg_out_o, .phase_a_pos_out_oe_o,
  .phase_b_neg_out_oe_o, .phase_a_neg_out_oe_o, .phase_b_pos_out_oe_o, .angle_home_monitor_o,
  .angle_home_monitor_oe_o, .chop_oscillator_tick_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o);
module tb_step_phase_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 0, reset_n_i = 0, cyc = 0, stb = 0, we = 0;
  logic        stp, dir, en, arst, ap, an, bp, bn, aoe, moe, tick, ack;
  logic [2:0]  sel;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat;
  int          error_cnt = 0, checks = 0, tcnt = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // Counts ticks by non-blocking update, so a read at the same edge never races the increment.
  always @(posedge ref_clk_i) if (tick === 1'b1) tcnt <= tcnt + 1;
  sps_host_model host_inst (.ref_clk_i, .step_o(stp), .dir_o(dir), .en_o(en), .arst_o(arst), .sel_o(sel));
  sps_step_phase_sequencer #(.CHOP_CYC(8)) sps_step_phase_sequencer_inst (.ref_clk_i, .reset_n_i,
    .step_pulse_i(stp), .rotation_direction_in_i(dir), .output_enable_i(en), .angle_reset_i(arst),
    .step_res_sel_bit0_i(sel[2]), .step_res_sel_bit1_i(sel[1]), .step_res_sel_bit2_i(sel[0]),
    .phase_a_pos_out_o(ap), .phase_a_neg_out_o(an), .phase_b_pos_out_o(bp), .phase_b_neg_out_o(bn),
    .phase_a_pos_out_oe_o(aoe), .phase_a_neg_out_oe_o(), .phase_b_pos_out_oe_o(), .phase_b_neg_out_oe_o(),
    .angle_home_monitor_o(), .angle_home_monitor_oe_o(moe), .chop_oscillator_tick_o(tick), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin @(posedge ref_clk_i); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n >= 20) error_cnt++;
    @(posedge ref_clk_i);
  endtask
  // Expected bridge legs {a+, a-, b+, b-} for an angle index.
  function automatic logic [3:0] legs(input logic [6:0] x);
    legs[3:2] = (x < 32 || x > 96) ? 2'b10 : (x == 32 || x == 96) ? 2'b00 : 2'b01;
    legs[1:0] = (x > 0 && x < 64) ? 2'b10 : (x == 0 || x == 64) ? 2'b00 : 2'b01;
  endfunction
  // Angle increment of a selector code.
  function automatic logic [6:0] stepsz(input int c);
    logic [6:0] t [8] = '{0, 32, 16, 8, 16, 4, 2, 1};
    return t[c];
  endfunction
  // Reads status and compares angle, mode, bridge legs and monitor.
  task automatic check_state(input logic [6:0] x, input int c);
    logic [31:0] q;
    wb(0, `SPS_ADR_STATUS, 0, q);
    `CHK(q[6:0], x)
    `CHK(q[15:8], 8'h01 << c)
    `CHK({ap, an, bp, bn}, legs(x))
    `CHK(moe, x == `SPS_ANGLE_INIT)
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [6:0]  x;
    int          n, k;
    logic        d;
    void'($urandom(32'h84b8));
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    wb(0, `SPS_ADR_CTRL, 0, q);
    `CHK(q, 32'h2)
    wb(0, 8'h40, 0, q);
    `CHK(q, 32'h0)
    k = tcnt;
    host_inst.steps(3, 1);
    `CHK(tcnt - k, 0)
    `CHK(aoe, 1'b0)
    $display("test reset done");
    host_inst.en_o <= 1'b1;
    for (int c = 1; c < 8; c++) begin
      host_inst.mode(c[2:0]);
      x = `SPS_ANGLE_INIT;
      check_state(x, c);
      repeat (2) begin
        n = $urandom_range(1, 40);
        d = 1'($urandom_range(0, 1));
        host_inst.steps(n, d);
        x = d ? x + 7'(n * stepsz(c)) : x - 7'(n * stepsz(c));
        check_state(x, c);
      end
    end
    host_inst.mode(3'd7);
    host_inst.steps(16, 0);
    check_state(7'h0, 7);
    $display("test modes done");
    wb(1, `SPS_ADR_CTRL, 32'h3, q);
    host_inst.steps(3, 1);
    check_state(`SPS_ANGLE_INIT, 7);
    wb(1, `SPS_ADR_CTRL, 32'h2, q);
    $display("test angle reset done");
    host_inst.en_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    `CHK(aoe, 1'b0)
    host_inst.en_o <= 1'b1;
    wb(1, `SPS_ADR_CTRL, 32'h0, q);
    repeat (8) @(posedge ref_clk_i);
    `CHK(aoe, 1'b0)
    wb(1, `SPS_ADR_CTRL, 32'h2, q);
    k = tcnt;
    repeat (40) @(posedge ref_clk_i);
    `CHK(aoe, 1'b1)
    `CHK(tcnt - k, 5)
    host_inst.sel_o <= 3'd0;
    // A tick already in flight may still land while the selector passes the synchroniser.
    repeat (4) @(posedge ref_clk_i);
    k = tcnt;
    host_inst.steps(3, 1);
    `CHK(tcnt - k, 0)
    `CHK(aoe, 1'b0)
    host_inst.sel_o <= 3'd7;
    repeat (8) @(posedge ref_clk_i);
    check_state(`SPS_ANGLE_INIT, 7);
    $display("test enable done");
    print_verdict();
  end
endmodule // tb_step_phase_sequencer
